// ===== hw/wdu_pkg.sv
package wdu_pkg;

  // Oscillator and time-out figures
  localparam int OSC_KHZ = 128;
  localparam int TMO_MIN_MS = 16;
  localparam int BASE_CYC = TMO_MIN_MS * OSC_KHZ;
  localparam int CNT_W = 21;
  localparam logic [3:0] TSEL_MAX = 4'h9;

  // Timed change window, in core clock cycles
  localparam int CE_CYCLES = 4;
  localparam logic [1:0] CE_CNT_LOAD = 2'(CE_CYCLES - 1);

  // Register byte offsets
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_CAUSE = 5'h04;
  localparam logic [4:0] REG_ISTS = 5'h08;
  localparam logic [4:0] REG_IMSK = 5'h0c;
  localparam logic [4:0] REG_RESTART = 5'h10;
  localparam logic [4:0] REG_COUNT = 5'h14;

  // Control and status field positions
  localparam int B_FLAG = 7;
  localparam int B_IME = 6;
  localparam int B_TS3 = 5;
  localparam int B_CE = 4;
  localparam int B_RME = 3;
  localparam int B_TS_HI = 2;
  localparam int B_CAUSE_WD = 3;

  // Interrupt status bits
  localparam int EV_TMO = 0;
  localparam int EV_RST = 1;
  localparam int EV_W = 2;

  // Reset values
  localparam logic [3:0] TSEL_RST = 4'h0;
  localparam logic [EV_W-1:0] IMSK_RST = 2'h0;

  // Operating modes
  typedef enum logic [1:0] {
    MODE_STOP,
    MODE_IRQ,
    MODE_RST,
    MODE_BOTH
  } wdu_mode_t;

endpackage : wdu_pkg

// ===== hw/wdu_sync.sv
`timescale 1ns/1ps
module wdu_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // Two flip-flop synchroniser; first stage feeds only the second
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : wdu_sync

// ===== hw/wdu_watchdog_unit.sv
`timescale 1ns/1ps
module wdu_watchdog_unit
  import wdu_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Oscillator and fuse pins
  input wire logic osc_clk_pin,
  input wire logic always_on_fuse,
  // Processor core side
  input wire logic restart_req,
  input wire logic vector_ack,
  output logic wake_irq_req,
  output logic sys_reset,
  // Interrupt to software
  output logic irq
);

  logic [1:0] pin_s;
  logic osc_s;
  logic fuse_s;
  logic osc_d_q;
  logic tick;
  logic ack_q;
  logic bus_req;
  logic wr_fire;
  logic rd_fire;
  logic [7:0] wd;
  logic ctrl_w;
  logic open_w;
  logic chg_w;
  logic rme_q;
  logic ime_q;
  logic flag_q;
  logic cause_q;
  logic ce_q;
  logic [1:0] ce_cnt_q;
  logic [3:0] tsel_q;
  logic rme_eff;
  logic ime_eff;
  logic run;
  logic restart;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] limit_m1;
  logic [3:0] tcode;
  logic expire;
  logic tmo_evt;
  logic rst_evt;
  logic sys_rst_q;
  wdu_mode_t mode;
  logic [EV_W-1:0] ists_q;
  logic [EV_W-1:0] imsk_q;
  logic [EV_W-1:0] ists_rd_q;
  logic [31:0] rdata_d;

  // Oscillator and fuse pins cross into the core domain
  wdu_sync #(.W(2)) u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .async_in({always_on_fuse, osc_clk_pin}),
    .sync_out(pin_s)
  );

  assign osc_s = pin_s[0];
  assign fuse_s = pin_s[1];

  // Rising edge of the oscillator gives one counter tick
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      osc_d_q <= 1'b0;
    end else begin
      osc_d_q <= osc_s;
    end
  end

  assign tick = osc_s & ~osc_d_q;

  // Bus slave: one wait cycle, then the answer
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_q;
  assign wr_fire = avs_write & ack_q & avs_byteenable[0];
  assign rd_fire = avs_read & ack_q;
  assign wd = avs_writedata[7:0];

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req & ~ack_q;
    end
  end

  // Control register write classes
  assign ctrl_w = wr_fire & (avs_address == REG_CTRL);
  assign open_w = ctrl_w & wd[B_CE] & wd[B_RME];
  assign chg_w = ctrl_w & ce_q & ~wd[B_CE];

  // Effective mode bits, fuse and cause flag override
  assign rme_eff = fuse_s | rme_q | cause_q;
  assign ime_eff = ime_q & ~fuse_s;

  always_comb begin
    unique case ({rme_eff, ime_eff})
      2'b00: mode = MODE_STOP;
      2'b01: mode = MODE_IRQ;
      2'b10: mode = MODE_RST;
      2'b11: mode = MODE_BOTH;
    endcase
  end

  // Timed change window
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ce_q <= 1'b0;
      ce_cnt_q <= 2'h0;
    end else if (rst_evt) begin
      ce_q <= 1'b0;
      ce_cnt_q <= 2'h0;
    end else if (open_w) begin
      ce_q <= 1'b1;
      ce_cnt_q <= CE_CNT_LOAD;
    end else if (chg_w) begin
      ce_q <= 1'b0;
      ce_cnt_q <= 2'h0;
    end else if (ce_q) begin
      if (ce_cnt_q == 2'h0) begin
        ce_q <= 1'b0;
      end else begin
        ce_cnt_q <= ce_cnt_q - 2'h1;
      end
    end
  end

  // Reset mode enable: set any time, cleared only in the window
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rme_q <= 1'b0;
    end else if (chg_w) begin
      rme_q <= wd[B_RME] | cause_q;
    end else if (ctrl_w) begin
      rme_q <= rme_q | wd[B_RME];
    end
  end

  // Time-out selection changes only in the window or on a watchdog reset
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tsel_q <= TSEL_RST;
    end else if (rst_evt) begin
      tsel_q <= TSEL_RST;
    end else if (chg_w) begin
      tsel_q <= {wd[B_TS3], wd[B_TS_HI:0]};
    end
  end

  // Interrupt mode enable, dropped by vector in combined mode
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ime_q <= 1'b0;
    end else if (rst_evt) begin
      ime_q <= 1'b0;
    end else if (ctrl_w) begin
      ime_q <= wd[B_IME];
    end else if (vector_ack && rme_eff) begin
      ime_q <= 1'b0;
    end
  end

  // Time-out interrupt flag, a new time-out wins over a clear
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      flag_q <= 1'b0;
    end else if (tmo_evt) begin
      flag_q <= 1'b1;
    end else if (rst_evt) begin
      flag_q <= 1'b0;
    end else if ((ctrl_w && wd[B_FLAG]) || vector_ack) begin
      flag_q <= 1'b0;
    end
  end

  // Watchdog reset cause flag, kept across its own reset
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cause_q <= 1'b0;
    end else if (rst_evt) begin
      cause_q <= 1'b1;
    end else if (wr_fire && avs_address == REG_CAUSE && !wd[B_CAUSE_WD]) begin
      cause_q <= 1'b0;
    end
  end

  // Time-out limit from the select code, reserved codes use the longest
  assign tcode = (tsel_q > TSEL_MAX) ? TSEL_MAX : tsel_q;
  assign limit_m1 = CNT_W'((BASE_CYC << tcode) - 1);

  assign run = rme_eff | ime_eff;
  assign restart = restart_req | (wr_fire & (avs_address == REG_RESTART));
  assign expire = run & tick & ~restart & (cnt_q == limit_m1);

  // Oscillator tick counter
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else if (!run || restart || expire) begin
      cnt_q <= '0;
    end else if (tick) begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  // Action on expiry by mode
  always_comb begin
    tmo_evt = 1'b0;
    rst_evt = 1'b0;
    unique case (mode)
      MODE_STOP: begin
        tmo_evt = 1'b0;
      end
      MODE_IRQ: begin
        tmo_evt = expire;
      end
      MODE_RST: begin
        rst_evt = expire;
      end
      MODE_BOTH: begin
        if (flag_q) begin
          rst_evt = expire;
        end else begin
          tmo_evt = expire;
        end
      end
    endcase
  end

  // One-cycle system reset pulse
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sys_rst_q <= 1'b0;
    end else begin
      sys_rst_q <= rst_evt;
    end
  end

  assign sys_reset = sys_rst_q;
  assign wake_irq_req = flag_q & ime_eff;

  // Sticky event status, read clears only what was reported
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ists_q <= '0;
    end else begin
      ists_q <= (ists_q & ~(rd_fire && avs_address == REG_ISTS ? ists_rd_q : '0))
                | {rst_evt, tmo_evt};
    end
  end

  // Interrupt mask
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      imsk_q <= IMSK_RST;
    end else if (wr_fire && avs_address == REG_IMSK) begin
      imsk_q <= wd[EV_W-1:0];
    end
  end

  assign irq = |(ists_q & imsk_q);

  // Read data mux
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (avs_address)
      REG_CTRL: rdata_d[7:0] = {flag_q, ime_eff, tsel_q[3], ce_q, rme_eff, tsel_q[2:0]};
      REG_CAUSE: rdata_d[B_CAUSE_WD] = cause_q;
      REG_ISTS: rdata_d[EV_W-1:0] = ists_q;
      REG_IMSK: rdata_d[EV_W-1:0] = imsk_q;
      REG_COUNT: rdata_d[CNT_W-1:0] = cnt_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // Read data captured in the wait cycle
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      avs_readdata <= 32'h0000_0000;
      ists_rd_q <= '0;
    end else if (avs_read && !ack_q) begin
      avs_readdata <= rdata_d;
      ists_rd_q <= ists_q;
    end
  end

  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  sequence open_seq;
    open_w && !rst_evt;
  endsequence

  sequence window_seq;
    ce_q && ce_cnt_q == CE_CNT_LOAD;
  endsequence

  ce_open_a: assert property (open_seq |=> window_seq)
    else $error("change window did not open");

  ce_close_a: assert property (ce_q && ce_cnt_q == 2'h0 && !open_w |=> !ce_q)
    else $error("change window stayed open");

  fuse_lock_a: assert property (fuse_s |-> rme_eff && !ime_eff && !wake_irq_req)
    else $error("fuse did not force reset mode");

  cause_hold_a: assert property (cause_q |-> rme_eff && run)
    else $error("reset enable dropped while cause set");

  reset_pulse_a: assert property (rst_evt |=> sys_reset ##1 (!sys_reset && cause_q))
    else $error("system reset pulse wrong");

  tsel_guard_a: assert property (!ce_q && !rst_evt |=> $stable(tsel_q))
    else $error("selection changed outside window");

  rme_guard_a: assert property (!ce_q && rme_q |=> rme_q)
    else $error("reset enable cleared outside window");

  irq_mode_a: assert property (expire && mode == MODE_IRQ |=> flag_q && !sys_reset)
    else $error("interrupt mode expiry wrong");

  combined_a: assert property (expire && mode == MODE_BOTH && !flag_q
                               |=> flag_q && !sys_reset)
    else $error("combined mode first expiry wrong");

  vec_clear_a: assert property (vector_ack && rme_eff && !ctrl_w && !expire
                                |=> !ime_q && !flag_q)
    else $error("vector did not clear irq enable and flag");

  restart_a: assert property (restart |=> cnt_q == '0)
    else $error("restart did not clear counter");

  irq_out_a: assert property (tmo_evt && imsk_q[EV_TMO] && avs_address != REG_IMSK |=> irq)
    else $error("time-out event did not raise interrupt");

endmodule : wdu_watchdog_unit

// ===== verif/wdu_core_model.sv
`timescale 1ns/1ps
// Core-side stand-in: oscillator, restart and vector entry
module wdu_core_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Bench controls
  input wire logic kick,
  input wire logic auto_ack,
  // Watchdog side
  input wire logic wake_irq_req,
  output logic osc_clk_pin,
  output logic restart_req,
  output logic vector_ack
);
  logic [9:0] div_q;

  // Free-running fast oscillator, one tick every 4 core cycles
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      div_q <= 10'h0;
    end else begin
      div_q <= div_q + 10'h1;
    end
    osc_clk_pin <= div_q[1];
  end

  // Restart pulse every 1024 cycles while kicking
  always_ff @(posedge core_clk) restart_req <= nrst && kick && div_q == 10'h0;

  // One-cycle vector entry on a pending request
  always_ff @(posedge core_clk) vector_ack <= nrst && auto_ack && wake_irq_req && !vector_ack;
endmodule : wdu_core_model

// ===== verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import wdu_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h1;
  logic always_on_fuse = 1'b0;
  logic kick = 1'b0;
  logic auto_ack = 1'b0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, osc_clk_pin, restart_req, vector_ack;
  logic wake_irq_req, sys_reset, irq;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;
  int n_rst = 0;
  int n;

  wdu_watchdog_unit uut (.core_clk, .nrst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .osc_clk_pin,
    .always_on_fuse, .restart_req, .vector_ack, .wake_irq_req, .sys_reset, .irq);

  wdu_core_model core (.core_clk, .nrst, .kick, .auto_ack, .wake_irq_req,
    .osc_clk_pin, .restart_req, .vector_ack);

  // Clock
  initial begin
    forever #2 core_clk = ~core_clk;
  end

  // Reset pulse count and hang cut-off
  always @(posedge core_clk) begin
    cyc++;
    if (sys_reset === 1'b1) n_rst++;
    if (cyc == 80000) begin
      mismatches++;
      test_done();
    end
  end

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
      mismatches++;
    end
  endtask : chk

  // One bus request, held until the rising edge that samples waitrequest low
  task automatic bus(input logic we, input logic [4:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge core_clk);
    avs_write <= we;
    avs_read <= !we;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input string nm, input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, exp, q);
  endtask : rdc

  // Cycles until the request or the reset pulse shows
  task automatic wait_sig(input bit which, output int t);
    t = 0;
    while ((which ? sys_reset : wake_irq_req) !== 1'b1) begin
      @(negedge core_clk);
      t++;
    end
  endtask : wait_sig

  // Main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    rdc("ctrl", REG_CTRL, 32'h00);
    rdc("cause", REG_CAUSE, 32'h00);
    rdc("unmapped", 5'h18, 32'h00);
    wr(REG_CTRL, 32'h08);
    rdc("ctrl", REG_CTRL, 32'h08);
    wr(REG_CTRL, 32'h00);
    rdc("ctrl", REG_CTRL, 32'h08);
    wr(REG_CTRL, 32'h18);
    wr(REG_CTRL, 32'h01);
    rdc("ctrl", REG_CTRL, 32'h01);
    wr(REG_CTRL, 32'h19);
    rdc("ctrl", REG_CTRL, 32'h19);
    repeat (5) @(posedge core_clk);
    rdc("ctrl", REG_CTRL, 32'h09);
    wr(REG_CTRL, 32'h00);
    rdc("ctrl", REG_CTRL, 32'h09);
    avs_byteenable <= 4'h0;
    wr(REG_CTRL, 32'h40);
    avs_byteenable <= 4'h1;
    rdc("ctrl", REG_CTRL, 32'h09);
    wr(REG_CTRL, 32'h18);
    wr(REG_CTRL, 32'h01);
    // Interrupt mode, select 1
    wr(REG_IMSK, 32'h1);
    wr(REG_RESTART, 32'h0);
    wr(REG_CTRL, 32'h41);
    wait_sig(1'b0, n);
    chk("expiry", 32'd128, 32'((n + 64) / 128));
    chk("irq", 32'h1, irq);
    chk("reset count", 32'h0, n_rst);
    rdc("ctrl", REG_CTRL, 32'hc1);
    wr(REG_IMSK, 32'h0);
    repeat (2) @(negedge core_clk);
    chk("irq", 32'h0, irq);
    wr(REG_IMSK, 32'h1);
    repeat (2) @(negedge core_clk);
    chk("irq", 32'h1, irq);
    rdc("status", REG_ISTS, 32'h01);
    repeat (2) @(negedge core_clk);
    chk("irq", 32'h0, irq);
    wr(REG_CTRL, 32'hc1);
    rdc("ctrl", REG_CTRL, 32'h41);
    // Restarts keep it from expiring
    kick <= 1'b1;
    repeat (20000) @(posedge core_clk);
    kick <= 1'b0;
    chk("irq request", 32'h0, wake_irq_req);
    rdc("status", REG_ISTS, 32'h00);
    // Combined mode, select 0
    wr(REG_CTRL, 32'h18);
    wr(REG_CTRL, 32'h48);
    wr(REG_RESTART, 32'h0);
    auto_ack <= 1'b1;
    wait_sig(1'b0, n);
    chk("expiry", 32'd64, 32'((n + 64) / 128));
    repeat (4) @(negedge core_clk);
    rdc("ctrl", REG_CTRL, 32'h08);
    chk("reset count", 32'h0, n_rst);
    wait_sig(1'b1, n);
    repeat (2) @(negedge core_clk);
    chk("reset count", 32'h1, n_rst);
    rdc("cause", REG_CAUSE, 32'h08);
    rdc("ctrl", REG_CTRL, 32'h08);
    rdc("status", REG_ISTS, 32'h03);
    wr(REG_CTRL, 32'h18);
    wr(REG_CTRL, 32'h00);
    rdc("ctrl", REG_CTRL, 32'h08);
    wr(REG_CAUSE, 32'h0);
    wr(REG_CTRL, 32'h18);
    wr(REG_CTRL, 32'h00);
    rdc("ctrl", REG_CTRL, 32'h00);
    rdc("count", REG_COUNT, 32'h00);
    // Always-on fuse
    always_on_fuse <= 1'b1;
    wr(REG_CTRL, 32'h40);
    rdc("ctrl", REG_CTRL, 32'h08);
    wr(REG_CTRL, 32'h18);
    wr(REG_CTRL, 32'h00);
    rdc("ctrl", REG_CTRL, 32'h08);
    always_on_fuse <= 1'b0;
    wr(REG_CTRL, 32'h18);
    wr(REG_CTRL, 32'h00);
    rdc("ctrl", REG_CTRL, 32'h00);
    test_done();
  end
endmodule : tb_top
